// [bst_pkg.sv]
// Constants, register map and types shared by both ends of the self-test link.
// Assumes one 200 MHz system clock and software on a plain register port.
package bst_pkg;
  // Widths
  localparam int unsigned AW = 32;
  localparam int unsigned DW = 32;
  localparam int unsigned IW = 6;
  localparam int unsigned SW = 8;
  localparam int unsigned CW = 16;
  localparam int unsigned RATIO_W = 3;
  localparam int unsigned EVW = 3;
  localparam int unsigned PIPE_DEPTH = 2;
  // Register byte addresses
  localparam logic [AW-1:0] ADDR_DIV = 32'hFFFF_E108;
  localparam logic [AW-1:0] ADDR_CTRL = 32'hFFFF_E120;
  localparam logic [AW-1:0] ADDR_TOUT = 32'hFFFF_E124;
  localparam logic [AW-1:0] ADDR_STAT = 32'hFFFF_E128;
  localparam logic [AW-1:0] ADDR_INTST = 32'hFFFF_E12C;
  localparam logic [AW-1:0] ADDR_INTMSK = 32'hFFFF_E130;
  localparam logic [AW-1:0] ADDR_EXC = 32'hFFFF_E134;
  // Field positions
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_RESTART = 1;
  localparam int unsigned CTRL_CNT_LSB = 8;
  localparam int unsigned STAT_RUN = 3;
  localparam int unsigned STAT_FAILINT_LSB = 8;
  localparam int unsigned STAT_NEXTINT_LSB = 16;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_FAIL = 1;
  localparam int unsigned EV_TMO = 2;
  localparam int unsigned EXC_SELFTEST_RST = 5;
  // Reset values
  localparam logic [RATIO_W-1:0] DIV_RESET = 3'h0;
  localparam logic [DW-1:0] TOUT_RESET = 32'h0010_0000;
  localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;
  // Timing
  localparam int unsigned CYC_PER_INTERVAL = 1365;
  localparam int unsigned NUM_INTERVALS = 26;
  localparam int unsigned SYS_CLK_MHZ = 200;
  localparam int unsigned MAX_TEST_CLK_MHZ = 45;
  localparam int unsigned MIN_DIVIDE = (SYS_CLK_MHZ + MAX_TEST_CLK_MHZ - 1) / MAX_TEST_CLK_MHZ;
  // Pattern generator of the cores under test, and the controller states
  localparam logic [SW-1:0] LFSR_SEED = 8'hA5;
  localparam logic [SW-1:0] LFSR_TAPS = 8'hB8;
  typedef enum logic [1:0] {
    BST_IDLE = 2'b00,
    BST_RUN = 2'b01,
    BST_FIN = 2'b11
  } bst_state_t;
endpackage : bst_pkg

// [bst_link_if.sv]
// Link between the self-test controller and the lockstep core pair.
// Assumes both ends run on clk_sys with the same synchronous reset.
`timescale 1ns/100ps
interface bst_link_if (
  input wire logic clk_sys,
  input wire logic rst_n
);
  logic isolate;
  logic stTick;
  logic intStart;
  logic [bst_pkg::IW-1:0] intervalNum;
  logic cpuReset;
  logic [bst_pkg::SW-1:0] sigCore0;
  logic [bst_pkg::SW-1:0] sigCore1;
  // Controller end
  modport ctl (
    output isolate,
    output stTick,
    output intStart,
    output intervalNum,
    output cpuReset,
    input sigCore0,
    input sigCore1
  );
  // Core pair end
  modport core (
    input isolate,
    input stTick,
    input intStart,
    input intervalNum,
    input cpuReset,
    output sigCore0,
    output sigCore1
  );
endinterface : bst_link_if

// [bst_self_test_ctl.sv]
// Self-test controller: divided test clock, interval sequencing, compare unit, timeout.
// Assumes software on the plain register port and a core pair on the link.
//
// What this block does
// [RL1] Run split into independent test intervals
// [RL2] Run all intervals or a programmed count
// [RL3] Resume after last interval or restart
// [RL4] Core pair isolated while run is active
// [RL5] Failing interval number kept for software
// [RL6] Programmable timeout watches run duration
// [RL7] Software configures everything before enable
// [RL8] Run ends by resetting the processor
// [RL9] Software keeps test clock at most 45 MHz; the divider accepts ratio fields 0 to 3 too, MIN_DIVIDE unused
// [RL10] Test clock divided from processor clock
// [RL11] Each interval takes fixed test cycles
// [RL12] Pattern engine drives both lockstep cores
// [RL13] Compare unit checks both cores' outputs
// [RL14] Software initialises core registers first
// [RL15] Divide ratio one through eight
// [RL16] Delayed core clock uses same divider
// [RL17] Self-test reset sets exception flag
// [RL18] Compared signals delayed two clock cycles
// [RL19] Timeout flags failure, stops, resets processor
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module bst_self_test_ctl #(
  parameter int unsigned CycPerInterval = bst_pkg::CYC_PER_INTERVAL,
  parameter int unsigned NumIntervals = bst_pkg::NUM_INTERVALS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [bst_pkg::AW-1:0] regAddr,
  input wire logic [bst_pkg::DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [bst_pkg::DW-1:0] regRdData,
  output logic irq,
  bst_link_if.ctl link
);
  localparam logic [bst_pkg::IW-1:0] LAST_INT = bst_pkg::IW'(NumIntervals - 1);
  localparam logic [bst_pkg::IW-1:0] FULL_CNT = bst_pkg::IW'(NumIntervals);
  localparam logic [bst_pkg::CW-1:0] LAST_CYC = bst_pkg::CW'(CycPerInterval - 1);
  localparam logic [1:0] FILL_FULL = 2'(bst_pkg::PIPE_DEPTH);

  bst_pkg::bst_state_t state_ff;
  logic [bst_pkg::RATIO_W-1:0] ratio_ff;
  logic [bst_pkg::IW-1:0] intCount_ff;
  logic restart_ff;
  logic [bst_pkg::DW-1:0] tout_ff;
  logic [bst_pkg::EVW-1:0] intSt_ff;
  logic [bst_pkg::EVW-1:0] intMsk_ff;
  logic excFlag_ff;
  logic [bst_pkg::IW-1:0] failInt_ff;
  logic [bst_pkg::IW-1:0] nextInt_ff;
  logic [bst_pkg::IW-1:0] curInt_ff;
  logic [bst_pkg::IW-1:0] doneCnt_ff;
  logic [bst_pkg::CW-1:0] cycCnt_ff;
  logic [bst_pkg::DW-1:0] toCnt_ff;
  logic [bst_pkg::RATIO_W-1:0] divCnt_ff;
  logic tick_ff;
  logic intStart_ff;
  logic isolate_ff;
  logic cpuReset_ff;
  logic [bst_pkg::SW-1:0] pipe0_ff;
  logic [bst_pkg::SW-1:0] pipe1_ff;
  logic [1:0] fill_ff;
  logic [bst_pkg::DW-1:0] regRdData_ff;
  logic irq_ff;

  logic startReq;
  logic cmpFail;
  logic tmoHit;
  logic intEnd;
  logic runDone;
  logic runEnd;
  logic [bst_pkg::IW-1:0] runLen;
  logic [bst_pkg::IW-1:0] curIntInc;
  logic [bst_pkg::EVW-1:0] evSet;

  // Decode of run start and the run events
  assign startReq = regWr && (regAddr == bst_pkg::ADDR_CTRL) && regWrData[bst_pkg::CTRL_EN]
                    && (state_ff == bst_pkg::BST_IDLE); // RL7
  assign runLen = (intCount_ff == '0) ? FULL_CNT : intCount_ff; // RL2
  assign cmpFail = (state_ff == bst_pkg::BST_RUN) && tick_ff && !intStart_ff && (fill_ff == FILL_FULL)
                   && (pipe1_ff != link.sigCore1); // RL13
  assign tmoHit = (state_ff == bst_pkg::BST_RUN) && (toCnt_ff == '0); // RL19
  assign intEnd = (state_ff == bst_pkg::BST_RUN) && tick_ff && !intStart_ff && (cycCnt_ff == LAST_CYC); // RL11
  assign curIntInc = (curInt_ff == LAST_INT) ? '0 : curInt_ff + 1'b1;
  assign runDone = intEnd && ((doneCnt_ff + 1'b1 == runLen) || (curInt_ff == LAST_INT)); // RL2
  assign evSet[bst_pkg::EV_DONE] = runDone && !cmpFail && !tmoHit;
  assign evSet[bst_pkg::EV_FAIL] = cmpFail;
  assign evSet[bst_pkg::EV_TMO] = tmoHit && !cmpFail;
  assign runEnd = cmpFail || tmoHit || runDone; // RL11

  // Run sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= bst_pkg::BST_IDLE;
      curInt_ff <= '0;
      nextInt_ff <= '0;
      doneCnt_ff <= '0;
      failInt_ff <= '0;
      toCnt_ff <= bst_pkg::ZERO_WORD;
      intStart_ff <= 1'b0;
    end else begin
      intStart_ff <= 1'b0;
      case (state_ff)
        bst_pkg::BST_IDLE: begin
          if (startReq) begin
            state_ff <= bst_pkg::BST_RUN;
            curInt_ff <= regWrData[bst_pkg::CTRL_RESTART] ? '0 : nextInt_ff; // RL3
            doneCnt_ff <= '0;
            toCnt_ff <= tout_ff; // RL6
            intStart_ff <= 1'b1; // RL1
          end
        end
        bst_pkg::BST_RUN: begin
          toCnt_ff <= toCnt_ff - 1'b1; // RL6
          if (cmpFail) begin
            failInt_ff <= curInt_ff; // RL5
            state_ff <= bst_pkg::BST_FIN;
          end else if (tmoHit) begin
            state_ff <= bst_pkg::BST_FIN; // RL19
          end else if (intEnd) begin
            nextInt_ff <= curIntInc; // RL3
            doneCnt_ff <= doneCnt_ff + 1'b1;
            if (runDone) begin
              state_ff <= bst_pkg::BST_FIN;
            end else begin
              curInt_ff <= curIntInc;
              intStart_ff <= 1'b1; // RL1
            end
          end
        end
        bst_pkg::BST_FIN: begin
          state_ff <= bst_pkg::BST_IDLE;
        end
        default: begin
          state_ff <= bst_pkg::BST_IDLE;
        end
      endcase
    end
  end

  // Isolation from run start through the run, and processor reset at the end of a run
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      isolate_ff <= 1'b0;
      cpuReset_ff <= 1'b0;
    end else begin
      isolate_ff <= startReq || (state_ff == bst_pkg::BST_RUN); // RL4
      cpuReset_ff <= (state_ff == bst_pkg::BST_FIN); // RL8
    end
  end

  // Test clock divider, ratio field plus one
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_ff != bst_pkg::BST_RUN) begin
      divCnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      divCnt_ff <= (divCnt_ff == ratio_ff) ? '0 : divCnt_ff + 1'b1; // RL15
      tick_ff <= (divCnt_ff == ratio_ff) && !runEnd; // RL10 RL16
    end
  end

  // Test cycle counter within an interval
  always_ff @(posedge clk_sys) begin
    if (!rst_n || intStart_ff) begin
      cycCnt_ff <= '0;
    end else if (tick_ff && state_ff == bst_pkg::BST_RUN) begin
      cycCnt_ff <= (cycCnt_ff == LAST_CYC) ? '0 : cycCnt_ff + 1'b1; // RL11
    end
  end

  // Compare pipe: core 0 delayed to meet the later core 1
  always_ff @(posedge clk_sys) begin
    if (!rst_n || intStart_ff) begin
      pipe0_ff <= '0;
      pipe1_ff <= '0;
      fill_ff <= '0;
    end else if (tick_ff) begin
      pipe0_ff <= link.sigCore0; // RL18
      pipe1_ff <= pipe0_ff; // RL18
      fill_ff <= (fill_ff == FILL_FULL) ? fill_ff : fill_ff + 1'b1;
    end
  end

  // Software-written configuration
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ratio_ff <= bst_pkg::DIV_RESET;
      intCount_ff <= '0;
      restart_ff <= 1'b0;
      tout_ff <= bst_pkg::TOUT_RESET;
      intMsk_ff <= '0;
    end else if (regWr && state_ff == bst_pkg::BST_IDLE) begin
      case (regAddr)
        bst_pkg::ADDR_DIV: ratio_ff <= regWrData[bst_pkg::RATIO_W-1:0]; // RL10
        bst_pkg::ADDR_CTRL: begin
          intCount_ff <= regWrData[bst_pkg::CTRL_CNT_LSB +: bst_pkg::IW]; // RL2
          restart_ff <= regWrData[bst_pkg::CTRL_RESTART]; // RL3
        end
        bst_pkg::ADDR_TOUT: tout_ff <= regWrData; // RL6
        bst_pkg::ADDR_INTMSK: intMsk_ff <= regWrData[bst_pkg::EVW-1:0];
        default: ;
      endcase
    end
  end

  // Sticky event and exception flags, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      intSt_ff <= '0;
      excFlag_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      intSt_ff <= evSet | (intSt_ff & ~((regWr && regAddr == bst_pkg::ADDR_INTST)
                  ? regWrData[bst_pkg::EVW-1:0] : '0));
      if (state_ff == bst_pkg::BST_FIN) begin
        excFlag_ff <= 1'b1; // RL17
      end else if (regWr && regAddr == bst_pkg::ADDR_EXC && regWrData[bst_pkg::EXC_SELFTEST_RST]) begin
        excFlag_ff <= 1'b0;
      end
      irq_ff <= |(intSt_ff & intMsk_ff);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !regRd) begin
      regRdData_ff <= bst_pkg::ZERO_WORD;
    end else begin
      regRdData_ff <= bst_pkg::ZERO_WORD;
      case (regAddr)
        bst_pkg::ADDR_DIV: regRdData_ff[bst_pkg::RATIO_W-1:0] <= ratio_ff;
        bst_pkg::ADDR_CTRL: begin
          regRdData_ff[bst_pkg::CTRL_EN] <= (state_ff != bst_pkg::BST_IDLE);
          regRdData_ff[bst_pkg::CTRL_RESTART] <= restart_ff;
          regRdData_ff[bst_pkg::CTRL_CNT_LSB +: bst_pkg::IW] <= intCount_ff;
        end
        bst_pkg::ADDR_TOUT: regRdData_ff <= tout_ff;
        bst_pkg::ADDR_STAT: begin
          regRdData_ff[bst_pkg::EVW-1:0] <= intSt_ff; // RL8
          regRdData_ff[bst_pkg::STAT_RUN] <= (state_ff != bst_pkg::BST_IDLE);
          regRdData_ff[bst_pkg::STAT_FAILINT_LSB +: bst_pkg::IW] <= failInt_ff; // RL5
          regRdData_ff[bst_pkg::STAT_NEXTINT_LSB +: bst_pkg::IW] <= nextInt_ff;
        end
        bst_pkg::ADDR_INTST: regRdData_ff[bst_pkg::EVW-1:0] <= intSt_ff;
        bst_pkg::ADDR_INTMSK: regRdData_ff[bst_pkg::EVW-1:0] <= intMsk_ff;
        bst_pkg::ADDR_EXC: regRdData_ff[bst_pkg::EXC_SELFTEST_RST] <= excFlag_ff;
        default: ;
      endcase
    end
  end

  // Outputs
  assign regRdData = regRdData_ff;
  assign irq = irq_ff;
  assign link.isolate = isolate_ff;
  assign link.stTick = tick_ff;
  assign link.intStart = intStart_ff;
  assign link.intervalNum = curInt_ff;
  assign link.cpuReset = cpuReset_ff;
endmodule : bst_self_test_ctl

// [bst_core_pair.sv]
// Lockstep core pair under test: one shared pattern engine, second core its copy two ticks late.
// Assumes the controller drives ticks and interval starts on the link.
`timescale 1ns/100ps
module bst_core_pair (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic faultInject,
  output logic isolated,
  output logic cpuResetSeen,
  bst_link_if.core link
);
  logic [bst_pkg::SW-1:0] lfsr_ff;
  logic [bst_pkg::SW-1:0] dly0_ff;
  logic [bst_pkg::SW-1:0] dly1_ff;
  logic [bst_pkg::SW-1:0] nxt_lfsr;
  logic isolated_ff;
  logic cpuResetSeen_ff;
  logic faultMeta_ff;
  logic fault_ff;

  // Galois shift step of the pattern engine
  assign nxt_lfsr = lfsr_ff[0] ? ((lfsr_ff >> 1) ^ bst_pkg::LFSR_TAPS) : (lfsr_ff >> 1); // RL12

  // Pattern engine, reseeded from a known value at each interval start
  always_ff @(posedge clk_sys) begin
    if (!rst_n || link.cpuReset) begin
      lfsr_ff <= bst_pkg::LFSR_SEED; // RL14
      dly0_ff <= '0;
      dly1_ff <= '0;
    end else if (link.intStart) begin
      lfsr_ff <= bst_pkg::LFSR_SEED ^ {{(bst_pkg::SW - bst_pkg::IW){1'b0}}, link.intervalNum}; // RL1
      dly0_ff <= '0;
      dly1_ff <= '0;
    end else if (link.stTick && link.isolate) begin
      lfsr_ff <= nxt_lfsr;
      dly0_ff <= lfsr_ff; // RL16
      dly1_ff <= dly0_ff; // RL16
    end
  end

  // Fault pin through two flip-flops, plus link copies
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      faultMeta_ff <= 1'b0;
      fault_ff <= 1'b0;
      isolated_ff <= 1'b0;
      cpuResetSeen_ff <= 1'b0;
    end else begin
      faultMeta_ff <= faultInject;
      fault_ff <= faultMeta_ff;
      isolated_ff <= link.isolate; // RL4
      cpuResetSeen_ff <= link.cpuReset; // RL8
    end
  end

  // Outputs
  assign link.sigCore0 = lfsr_ff;
  assign link.sigCore1 = dly1_ff ^ {{(bst_pkg::SW - 1){1'b0}}, fault_ff};
  assign isolated = isolated_ff;
  assign cpuResetSeen = cpuResetSeen_ff;
endmodule : bst_core_pair

// [bst_ctl_asserts.sv]
// Checker for the link between the self-test controller and the core pair.
// Assumes the bench instantiates it beside the link with the bench's parameters.
`timescale 1ns/100ps
module bst_ctl_asserts #(
  parameter int unsigned CycPerInterval = bst_pkg::CYC_PER_INTERVAL,
  parameter int unsigned NumIntervals = bst_pkg::NUM_INTERVALS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic isolate,
  input wire logic stTick,
  input wire logic intStart,
  input wire logic [bst_pkg::IW-1:0] intervalNum,
  input wire logic cpuReset,
  input wire logic [bst_pkg::SW-1:0] sigCore0,
  input wire logic [bst_pkg::SW-1:0] sigCore1
);
  logic [15:0] tickCnt_ff;
  logic [bst_pkg::IW-1:0] lastNum_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Ticks seen since the latest interval start
  always_ff @(posedge clk_sys) begin
    if (!rst_n || intStart) tickCnt_ff <= 16'h0000;
    else if (stTick) tickCnt_ff <= tickCnt_ff + 16'h0001;
  end
  // Number of the latest interval started
  always_ff @(posedge clk_sys) begin
    if (!rst_n) lastNum_ff <= 6'h00;
    else if (intStart) lastNum_ff <= intervalNum;
  end
  a_tick_isolated: assert property (stTick |-> isolate) else $error("tick outside isolation");
  a_start_isolated: assert property (intStart |-> isolate) else $error("start outside isolation");
  a_reset_single: assert property (cpuReset |=> !cpuReset) else $error("cpu reset too long");
  a_reset_releases: assert property (cpuReset |-> ##[0:1] !isolate) else $error("isolation kept");
  a_run_starts: assert property ($rose(isolate) |-> intStart) else $error("run without start");
  a_tick_bound: assert property (stTick && !intStart |-> tickCnt_ff < CycPerInterval)
    else $error("interval too long");
  a_interval_range: assert property (intStart |-> intervalNum < NumIntervals)
    else $error("interval out of range");
  a_interval_next: assert property (intStart && $past(isolate) |-> intervalNum == lastNum_ff + 6'h01)
    else $error("interval skipped");
  a_start_reseed: assert property (intStart |=> sigCore0 == (bst_pkg::LFSR_SEED
    ^ {{(bst_pkg::SW - bst_pkg::IW){1'b0}}, $past(intervalNum)})) else $error("pattern not reseeded");
  a_lag_cleared: assert property (intStart |=> sigCore1[bst_pkg::SW-1:1] == '0)
    else $error("core one lag not cleared");
endmodule : bst_ctl_asserts

// [tb_top.sv]
// Bench for the self-test controller and core pair joined by the link.
// Assumes a 200 MHz clock and shortened interval length and count.
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned CPI = 5;
  localparam int unsigned NI = 4;
  localparam logic [31:0] Z = 32'h0000_0000;
  typedef struct {logic [31:0] a; logic w; logic [31:0] d; logic [31:0] e;} bst_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] regAddr = Z;
  logic [31:0] regWrData = Z;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic faultInject = 1'b0;
  logic [31:0] regRdData;
  logic irq;
  logic isolated;
  logic cpuResetSeen;
  logic [31:0] v;
  logic [31:0] firstNum;
  int bad_count = 0;
  int num_checks = 0;
  int starts;
  int ticks;
  int gap;
  int lastT;
  bst_row_t rows[11];
  bst_link_if link (.clk_sys(clk_sys), .rst_n(rst_n));
  bst_self_test_ctl #(.CycPerInterval(CPI), .NumIntervals(NI)) u_bst_self_test_ctl (.clk_sys(clk_sys),
    .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .irq(irq), .link(link));
  bst_core_pair u_bst_core_pair (.clk_sys(clk_sys), .rst_n(rst_n), .faultInject(faultInject),
    .isolated(isolated), .cpuResetSeen(cpuResetSeen), .link(link));
  bst_ctl_asserts #(.CycPerInterval(CPI), .NumIntervals(NI)) u_bst_ctl_asserts (.clk_sys(clk_sys),
    .rst_n(rst_n), .isolate(link.isolate), .stTick(link.stTick), .intStart(link.intStart),
    .intervalNum(link.intervalNum), .cpuReset(link.cpuReset), .sigCore0(link.sigCore0),
    .sigCore1(link.sigCore1));
  // Clock
  always #2.5 clk_sys = ~clk_sys;
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Strobe stays up for a following write; the next task or caller lowers it
  task wr(input logic [31:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
  endtask : wr
  task rd(input logic [31:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    regWr <= 1'b0;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    v = regRdData;
    @(posedge clk_sys);
  endtask : rd
  // Start a run and watch the link until the processor reset
  task run(input logic [31:0] ctl);
    int i;
    starts = 0;
    ticks = 0;
    gap = 0;
    lastT = 0;
    firstNum = 32'hFFFF_FFFF;
    wr(bst_pkg::ADDR_CTRL, ctl);
    regWr <= 1'b0;
    for (i = 0; i < 4000; i++) begin
      @(negedge clk_sys);
      if (link.intStart) begin
        if (starts == 0) firstNum = {26'h000_0000, link.intervalNum};
        starts++;
      end
      if (link.stTick && !link.intStart) begin
        if (ticks == 0) check("isolated", {31'h0000_0000, isolated}, 32'h0000_0001);
        if (ticks == 1) gap = i - lastT;
        lastT = i;
        ticks++;
      end
      if (link.cpuReset) break;
    end
    if (i == 4000) begin
      check("run end", 32'h0000_0000, 32'h0000_0001);
      close_out();
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("reset seen", {31'h0000_0000, cpuResetSeen}, 32'h0000_0001);
    check("released", {31'h0000_0000, isolated}, Z);
    @(posedge clk_sys);
  endtask : run
  initial begin : main
    int r;
    rows = '{'{bst_pkg::ADDR_DIV, 1'b0, Z, Z}, '{bst_pkg::ADDR_TOUT, 1'b0, Z, bst_pkg::TOUT_RESET},
      '{bst_pkg::ADDR_CTRL, 1'b0, Z, Z}, '{bst_pkg::ADDR_STAT, 1'b0, Z, Z}, '{bst_pkg::ADDR_INTST, 1'b0, Z, Z},
      '{bst_pkg::ADDR_INTMSK, 1'b0, Z, Z}, '{bst_pkg::ADDR_EXC, 1'b0, Z, Z}, '{32'hFFFF_E200, 1'b0, Z, Z},
      '{bst_pkg::ADDR_DIV, 1'b1, 32'h0000_0005, 32'h0000_0005},
      '{bst_pkg::ADDR_TOUT, 1'b1, 32'h0000_00C8, 32'h0000_00C8},
      '{bst_pkg::ADDR_INTMSK, 1'b1, 32'h0000_0007, 32'h0000_0007}};
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    check("isolate", {31'h0000_0000, link.isolate}, 32'h0000_0000);
    @(posedge clk_sys);
    // Register table rows
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rd(rows[k].a);
      check("register", v, rows[k].e);
    end
    wr(bst_pkg::ADDR_TOUT, 32'h0000_1000);
    // Every divide ratio, one interval each
    for (r = 0; r < 8; r++) begin
      wr(bst_pkg::ADDR_DIV, r);
      run(32'h0000_0103);
      check("tick gap", gap, r + 1);
      check("ticks", ticks, CPI);
    end
    check("irq", {31'h0000_0000, irq}, 32'h0000_0001);
    rd(bst_pkg::ADDR_EXC);
    check("exc flag", v & 32'h0000_0020, 32'h0000_0020);
    wr(bst_pkg::ADDR_EXC, 32'h0000_0020);
    wr(bst_pkg::ADDR_INTST, 32'h0000_0007);
    rd(bst_pkg::ADDR_EXC);
    check("exc clear", v, Z);
    check("irq clear", {31'h0000_0000, irq}, Z);
    // Restart, then resume at the next interval
    wr(bst_pkg::ADDR_DIV, Z);
    run(32'h0000_0103);
    check("restart", firstNum, Z);
    rd(bst_pkg::ADDR_STAT);
    check("next", {26'h000_0000, v[21:16]}, 32'h0000_0001);
    run(32'h0000_0101);
    check("resume", firstNum, 32'h0000_0001);
    // Core mismatch in interval two
    faultInject <= 1'b1;
    run(32'h0000_0101);
    faultInject <= 1'b0;
    rd(bst_pkg::ADDR_STAT);
    check("fail interval", {26'h000_0000, v[13:8]}, 32'h0000_0002);
    rd(bst_pkg::ADDR_INTST);
    check("fail event", v & 32'h0000_0002, 32'h0000_0002);
    // Full masked run over all intervals
    wr(bst_pkg::ADDR_INTST, 32'h0000_0007);
    wr(bst_pkg::ADDR_INTMSK, Z);
    run(32'h0000_0003);
    check("starts", starts, NI);
    check("all ticks", ticks, NI * CPI);
    check("masked irq", {31'h0000_0000, irq}, Z);
    rd(bst_pkg::ADDR_INTST);
    check("done", v, 32'h0000_0001);
    // Timeout in the first interval
    wr(bst_pkg::ADDR_INTST, 32'h0000_0007);
    wr(bst_pkg::ADDR_TOUT, 32'h0000_000A);
    wr(bst_pkg::ADDR_DIV, 32'h0000_0007);
    run(32'h0000_0003);
    check("tmo starts", starts, 1);
    rd(bst_pkg::ADDR_INTST);
    check("timeout", v, 32'h0000_0004);
    // Reset in mid-run
    wr(bst_pkg::ADDR_CTRL, 32'h0000_0003);
    regWr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(bst_pkg::ADDR_TOUT);
    check("tout reset", v, bst_pkg::TOUT_RESET);
    check("isolate off", {31'h0000_0000, link.isolate}, Z);
    close_out();
  end
endmodule : tb_top
